// ==== hdl/umcc_map.svh ====
`ifndef UMCC_MAP_SVH
`define UMCC_MAP_SVH
// Register offsets on the plain register port
`define UMCC_ADDR_FIFO_CONTROL 4'h2
`define UMCC_ADDR_LINE_CONTROL 4'h3
`define UMCC_ADDR_ENHANCED 4'h4
`define UMCC_ADDR_ADDITIONAL 4'h5
`define UMCC_ADDR_INDEX 4'h6
`define UMCC_ADDR_INDEXED_DATA 4'h7
`define UMCC_ADDR_RX_FILL 4'h8
`define UMCC_ADDR_TX_FILL 4'h9
`define UMCC_ADDR_DIVISOR_LO 4'ha
`define UMCC_ADDR_DIVISOR_HI 4'hb
`define UMCC_ADDR_MODE_STATUS 4'hc
// Indexed register space offsets
`define UMCC_IDX_ADD_CTL 8'h00
`define UMCC_IDX_CLK_SEL 8'h02
`define UMCC_IDX_OVS_CNT 8'h03
`define UMCC_IDX_PRESCALE 8'h01
`define UMCC_IDX_RX_TRIG 8'h04
`define UMCC_IDX_FLOW_LO 8'h05
`define UMCC_IDX_FLOW_HI 8'h06
// Field positions
`define UMCC_FIFO_CTL_ENABLE 0
`define UMCC_FIFO_CTL_SIZE 5
`define UMCC_LINE_CTL_DIV_ACCESS 7
`define UMCC_ENH_FEAT_ENH 4
`define UMCC_ADD_CTL_TRIG 5
// Reset values and special codes
`define UMCC_PRESCALE_RESET 8'h20
`define UMCC_OVS_CNT_RESET 8'h00
`define UMCC_CLK_SEL_RESET 8'h00
`define UMCC_ADD_CTL_RESET 8'h00
`define UMCC_LINE_CTL_RESET 8'h00
`define UMCC_LINE_CTL_ENH_KEY 8'hbf
`define UMCC_DIV_RESET 16'h0001
`define UMCC_OVS_DEFAULT 5'h10
`define UMCC_OVS_MIN 4'h4
`define UMCC_FIFO_CTL_IGNORE_MASK 8'h0f
`endif

// ==== hdl/umcc_pkg.sv ====
package umcc_pkg;
	typedef logic [7:0] umcc_byte_t;
	typedef logic [3:0] umcc_addr_t;
	typedef logic [7:0] umcc_depth_t;
	typedef enum logic [5:0] {
		UMCC_MODE_450 = 6'h01,
		UMCC_MODE_550 = 6'h02,
		UMCC_MODE_X550 = 6'h04,
		UMCC_MODE_650 = 6'h08,
		UMCC_MODE_750 = 6'h10,
		UMCC_MODE_950 = 6'h20
	} umcc_mode_e;
endpackage

// ==== hdl/umcc_prescaler.sv ====
`timescale 1ns/1ps
`include "umcc_map.svh"
// Fractional M+N/8 clock divider producing one-cycle enable pulses
module umcc_prescaler (
	input wire logic mclk,
	input wire logic reset,
	input wire logic [7:0] ratio,
	output logic tick
);
	import umcc_pkg::*;
	logic [8:0] acc_q;
	logic [8:0] acc_d;
	logic tick_q;
	logic tick_d;
	logic [8:0] step;
	logic [8:0] next_acc;

	// Ratio in eighths; M of zero gives a ratio of exactly one, N ignored, so the divider never stalls
	always_comb begin
		step = (ratio[7:3] == 5'h00) ? 9'h008 : {1'b0, ratio};
		next_acc = acc_q + 9'h008;
		acc_d = next_acc;
		tick_d = 1'b0;
		if (next_acc >= step) begin
			acc_d = next_acc - step;
			tick_d = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			acc_q <= 9'h000;
			tick_q <= 1'b0;
		end else begin
			acc_q <= acc_d;
			tick_q <= tick_d;
		end
	end

	assign tick = tick_q;
endmodule

// ==== hdl/umcc_config.sv ====
`timescale 1ns/1ps
`include "umcc_map.svh"
module umcc_config (
	input wire logic mclk,
	input wire logic reset,
	input wire umcc_pkg::umcc_addr_t reg_addr,
	input wire umcc_pkg::umcc_byte_t reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output umcc_pkg::umcc_byte_t reg_rdata,
	input wire logic depth_select_pin,
	input wire umcc_pkg::umcc_byte_t rx_fill_level,
	input wire umcc_pkg::umcc_byte_t tx_fill_level,
	input wire logic ring_ind_in,
	input wire logic data_set_ready_in,
	output umcc_pkg::umcc_depth_t fifo_depth,
	output umcc_pkg::umcc_mode_e uart_mode,
	output logic legacy_extras_en,
	output logic extended_en,
	output logic arb_trigger_en,
	output umcc_pkg::umcc_byte_t fifo_ctl_eff,
	output umcc_pkg::umcc_byte_t rx_trigger_level,
	output umcc_pkg::umcc_byte_t flow_low_threshold,
	output umcc_pkg::umcc_byte_t flow_high_threshold,
	output logic [4:0] sample_count,
	output logic sample_tick,
	output logic tx_bit_tick,
	output logic rx_bit_tick,
	output logic tx_clk_out,
	output logic tx_clk_out_en
);
	import umcc_pkg::*;

	logic [7:0] fctl_q, fctl_d;
	logic [7:0] lctl_q, lctl_d;
	logic [7:0] efeat_q, efeat_d;
	logic [7:0] actl_q, actl_d;
	logic [7:0] idx_q, idx_d;
	logic [7:0] psc_q, psc_d;
	logic [7:0] ovsr_q, ovsr_d;
	logic [7:0] csel_q, csel_d;
	logic [7:0] rtrig_q, rtrig_d;
	logic [7:0] flo_q, flo_d;
	logic [7:0] fhi_q, fhi_d;
	logic [15:0] div_q, div_d;
	logic [7:0] rdata_q, rdata_d;
	logic [7:0] depth_q, depth_d;
	umcc_mode_e mode_q, mode_d;
	logic legacy_q, legacy_d;
	logic ext_q, ext_d;
	logic arb_q, arb_d;
	logic [7:0] fce_q, fce_d;
	logic [4:0] ovs_q, ovs_d;
	logic [15:0] divc_q, divc_d;
	logic [4:0] tsc_q, tsc_d;
	logic [4:0] rsc_q, rsc_d;
	logic [15:0] tdiv_q, tdiv_d;
	logic [15:0] rdiv_q, rdiv_d;
	logic samp_q, samp_d;
	logic txb_q, txb_d;
	logic rxb_q, rxb_d;
	logic ri_q, dsr_q;
	logic tck_q, tck_d;
	logic tcken_q, tcken_d;
	logic presc_tick;
	logic ext_tx, ext_rx, tx_edge, rx_edge;

	// Fractional prescaler on the system clock
	umcc_prescaler u_presc (
		.mclk(mclk),
		.reset(reset),
		.ratio(psc_q),
		.tick(presc_tick)
	);

	// Register writes and read data
	always_comb begin
		fctl_d = fctl_q;
		lctl_d = lctl_q;
		efeat_d = efeat_q;
		actl_d = actl_q;
		idx_d = idx_q;
		psc_d = psc_q;
		ovsr_d = ovsr_q;
		csel_d = csel_q;
		rtrig_d = rtrig_q;
		flo_d = flo_q;
		fhi_d = fhi_q;
		div_d = div_q;
		rdata_d = 8'h00;
		if (reg_write) begin
			case (reg_addr)
				`UMCC_ADDR_FIFO_CONTROL: begin
					fctl_d = reg_wdata;
					// Size bit guarded by divisor access
					if (!lctl_q[`UMCC_LINE_CTL_DIV_ACCESS]) begin
						fctl_d[`UMCC_FIFO_CTL_SIZE] = fctl_q[`UMCC_FIFO_CTL_SIZE];
					end
				end
				`UMCC_ADDR_LINE_CONTROL: begin
					// Enhanced key sets divisor access only
					if (reg_wdata == `UMCC_LINE_CTL_ENH_KEY) begin
						lctl_d[`UMCC_LINE_CTL_DIV_ACCESS] = 1'b1;
					end else begin
						lctl_d = reg_wdata;
					end
				end
				`UMCC_ADDR_ENHANCED: efeat_d = reg_wdata;
				`UMCC_ADDR_ADDITIONAL: actl_d = reg_wdata;
				`UMCC_ADDR_INDEX: idx_d = reg_wdata;
				`UMCC_ADDR_DIVISOR_LO: div_d[7:0] = reg_wdata;
				`UMCC_ADDR_DIVISOR_HI: div_d[15:8] = reg_wdata;
				`UMCC_ADDR_INDEXED_DATA: begin
					case (idx_q)
						`UMCC_IDX_ADD_CTL: actl_d = reg_wdata;
						`UMCC_IDX_PRESCALE: psc_d = reg_wdata;
						`UMCC_IDX_CLK_SEL: csel_d = reg_wdata;
						`UMCC_IDX_OVS_CNT: ovsr_d = reg_wdata;
						`UMCC_IDX_RX_TRIG: rtrig_d = reg_wdata;
						`UMCC_IDX_FLOW_LO: flo_d = reg_wdata;
						`UMCC_IDX_FLOW_HI: fhi_d = reg_wdata;
						default: ;
					endcase
				end
				default: ;
			endcase
		end
		if (reg_read) begin
			case (reg_addr)
				`UMCC_ADDR_FIFO_CONTROL: rdata_d = fctl_q;
				`UMCC_ADDR_LINE_CONTROL: rdata_d = lctl_q;
				`UMCC_ADDR_ENHANCED: rdata_d = efeat_q;
				`UMCC_ADDR_ADDITIONAL: rdata_d = actl_q;
				`UMCC_ADDR_INDEX: rdata_d = idx_q;
				`UMCC_ADDR_DIVISOR_LO: rdata_d = div_q[7:0];
				`UMCC_ADDR_DIVISOR_HI: rdata_d = div_q[15:8];
				`UMCC_ADDR_RX_FILL: rdata_d = rx_fill_level;
				`UMCC_ADDR_TX_FILL: rdata_d = tx_fill_level;
				`UMCC_ADDR_MODE_STATUS: rdata_d = {1'b0, depth_select_pin, mode_q};
				`UMCC_ADDR_INDEXED_DATA: begin
					case (idx_q)
						`UMCC_IDX_ADD_CTL: rdata_d = actl_q;
						`UMCC_IDX_PRESCALE: rdata_d = psc_q;
						`UMCC_IDX_CLK_SEL: rdata_d = csel_q;
						`UMCC_IDX_OVS_CNT: rdata_d = ovsr_q;
						`UMCC_IDX_RX_TRIG: rdata_d = rtrig_q;
						`UMCC_IDX_FLOW_LO: rdata_d = flo_q;
						`UMCC_IDX_FLOW_HI: rdata_d = fhi_q;
						default: rdata_d = 8'h00;
					endcase
				end
				default: rdata_d = 8'h00;
			endcase
		end
	end

	// Mode and depth decode, registered so outputs are flop driven
	always_comb begin
		depth_d = 8'h01;
		mode_d = UMCC_MODE_450;
		if (!fctl_q[`UMCC_FIFO_CTL_ENABLE]) begin
			depth_d = 8'h01;
			mode_d = UMCC_MODE_450;
		end else if (efeat_q[`UMCC_ENH_FEAT_ENH]) begin
			depth_d = 8'h80;
			mode_d = (actl_q != `UMCC_ADD_CTL_RESET) ? UMCC_MODE_950 : UMCC_MODE_650;
		end else if (depth_select_pin) begin
			depth_d = 8'h80;
			mode_d = UMCC_MODE_X550;
		end else if (fctl_q[`UMCC_FIFO_CTL_SIZE]) begin
			depth_d = 8'h80;
			mode_d = UMCC_MODE_750;
		end else begin
			depth_d = 8'h10;
			mode_d = UMCC_MODE_550;
		end
		// Legacy extras gated by enhanced clear
		legacy_d = ~efeat_q[`UMCC_ENH_FEAT_ENH];
		// Extended set gated by enhanced bit
		ext_d = efeat_q[`UMCC_ENH_FEAT_ENH];
		// Arbitrary triggers mask FIFO control upper bits
		arb_d = efeat_q[`UMCC_ENH_FEAT_ENH] & actl_q[`UMCC_ADD_CTL_TRIG];
		fce_d = arb_d ? (fctl_q & `UMCC_FIFO_CTL_IGNORE_MASK) : fctl_q;
		// Values 0 to 3 mean sixteen samples
		if (ovsr_q[3:0] < `UMCC_OVS_MIN) begin
			ovs_d = `UMCC_OVS_DEFAULT;
		end else begin
			// Exact sample count 4 to 15
			ovs_d = {1'b0, ovsr_q[3:0]};
		end
	end

	// External clock edges; pins are taken as synchronous
	assign ext_tx = csel_q[0];
	assign ext_rx = csel_q[1];
	assign tx_edge = ring_ind_in & ~ri_q;
	assign rx_edge = data_set_ready_in & ~dsr_q;

	// Baud timing: prescaler tick, divisor, then oversampling count
	always_comb begin
		divc_d = divc_q;
		samp_d = 1'b0;
		tsc_d = tsc_q;
		rsc_d = rsc_q;
		tdiv_d = tdiv_q;
		rdiv_d = rdiv_q;
		txb_d = 1'b0;
		rxb_d = 1'b0;
		tck_d = tck_q;
		if (presc_tick) begin
			if (divc_q + 16'h0001 >= div_q) begin
				divc_d = 16'h0000;
				samp_d = 1'b1;
			end else begin
				divc_d = divc_q + 16'h0001;
			end
		end
		// Bit tick after the oversampling count of sample ticks, or of external clock edges when selected
		if (ext_tx ? tx_edge : samp_q) begin
			if (tsc_q + 5'h01 >= ovs_q) begin
				tsc_d = 5'h00;
				txb_d = 1'b1;
			end else begin
				tsc_d = tsc_q + 5'h01;
			end
		end
		if (ext_rx ? rx_edge : samp_q) begin
			if (rsc_q + 5'h01 >= ovs_q) begin
				rsc_d = 5'h00;
				rxb_d = 1'b1;
			end else begin
				rsc_d = rsc_q + 5'h01;
			end
		end
		// Transmit clock out toggles once per bit
		if (txb_d) begin
			tck_d = ~tck_q;
		end
		tcken_d = csel_q[2];
	end

	// State registers
	always_ff @(posedge mclk) begin
		if (reset) begin
			fctl_q <= 8'h00;
			lctl_q <= `UMCC_LINE_CTL_RESET;
			efeat_q <= 8'h00;
			actl_q <= `UMCC_ADD_CTL_RESET;
			idx_q <= 8'h00;
			psc_q <= `UMCC_PRESCALE_RESET;
			ovsr_q <= `UMCC_OVS_CNT_RESET;
			csel_q <= `UMCC_CLK_SEL_RESET;
			rtrig_q <= 8'h00;
			flo_q <= 8'h00;
			fhi_q <= 8'h00;
			div_q <= `UMCC_DIV_RESET;
			rdata_q <= 8'h00;
			depth_q <= 8'h01;
			mode_q <= UMCC_MODE_450;
			legacy_q <= 1'b1;
			ext_q <= 1'b0;
			arb_q <= 1'b0;
			fce_q <= 8'h00;
			ovs_q <= `UMCC_OVS_DEFAULT;
			divc_q <= 16'h0000;
			tsc_q <= 5'h00;
			rsc_q <= 5'h00;
			tdiv_q <= 16'h0000;
			rdiv_q <= 16'h0000;
			samp_q <= 1'b0;
			txb_q <= 1'b0;
			rxb_q <= 1'b0;
			ri_q <= 1'b0;
			dsr_q <= 1'b0;
			tck_q <= 1'b0;
			tcken_q <= 1'b0;
		end else begin
			fctl_q <= fctl_d;
			lctl_q <= lctl_d;
			efeat_q <= efeat_d;
			actl_q <= actl_d;
			idx_q <= idx_d;
			psc_q <= psc_d;
			ovsr_q <= ovsr_d;
			csel_q <= csel_d;
			rtrig_q <= rtrig_d;
			flo_q <= flo_d;
			fhi_q <= fhi_d;
			div_q <= div_d;
			rdata_q <= rdata_d;
			depth_q <= depth_d;
			mode_q <= mode_d;
			legacy_q <= legacy_d;
			ext_q <= ext_d;
			arb_q <= arb_d;
			fce_q <= fce_d;
			ovs_q <= ovs_d;
			divc_q <= divc_d;
			tsc_q <= tsc_d;
			rsc_q <= rsc_d;
			tdiv_q <= tdiv_d;
			rdiv_q <= rdiv_d;
			samp_q <= samp_d;
			txb_q <= txb_d;
			rxb_q <= rxb_d;
			ri_q <= ring_ind_in;
			dsr_q <= data_set_ready_in;
			tck_q <= tck_d;
			tcken_q <= tcken_d;
		end
	end

	// Outputs straight from flops
	assign reg_rdata = rdata_q;
	assign fifo_depth = depth_q;
	assign uart_mode = mode_q;
	assign legacy_extras_en = legacy_q;
	assign extended_en = ext_q;
	assign arb_trigger_en = arb_q;
	assign fifo_ctl_eff = fce_q;
	assign rx_trigger_level = rtrig_q;
	assign flow_low_threshold = flo_q;
	assign flow_high_threshold = fhi_q;
	assign sample_count = ovs_q;
	assign sample_tick = samp_q;
	assign tx_bit_tick = txb_q;
	assign rx_bit_tick = rxb_q;
	assign tx_clk_out = tck_q;
	assign tx_clk_out_en = tcken_q;
endmodule

// ==== verification/umcc_config_chk.sv ====
`timescale 1ns/1ps
// Mode and sampling relations on the decoded outputs
module umcc_config_chk (
	input wire logic mclk,
	input wire logic reset,
	input wire logic depth_select_pin,
	input wire umcc_pkg::umcc_depth_t fifo_depth,
	input wire umcc_pkg::umcc_mode_e uart_mode,
	input wire logic legacy_extras_en,
	input wire logic extended_en,
	input wire logic arb_trigger_en,
	input wire umcc_pkg::umcc_byte_t fifo_ctl_eff,
	input wire logic [4:0] sample_count
);
	import umcc_pkg::*;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);
	property p_rst;
		$past(reset) |-> fifo_depth == 8'h01 && uart_mode == UMCC_MODE_450;
	endproperty
	a_rst: assert property (p_rst) else $error("no byte mode after reset");
	property p_off;
		!fifo_ctl_eff[0] |-> fifo_depth == 8'h01;
	endproperty
	a_off: assert property (p_off) else $error("depth not one");
	// Pin passes one registering stage; it must be steady for the two cycles before first
	property p_d16;
		fifo_ctl_eff[0] && !fifo_ctl_eff[5] && !extended_en && !depth_select_pin
			&& !$past(depth_select_pin) && !$past(depth_select_pin, 2) |-> fifo_depth == 8'h10;
	endproperty
	a_d16: assert property (p_d16) else $error("depth not 16");
	property p_pin;
		fifo_ctl_eff[0] && depth_select_pin && $past(depth_select_pin)
			&& $past(depth_select_pin, 2) |-> fifo_depth == 8'h80;
	endproperty
	a_pin: assert property (p_pin) else $error("pin depth not 128");
	property p_enh;
		fifo_ctl_eff[0] && extended_en |-> fifo_depth == 8'h80;
	endproperty
	a_enh: assert property (p_enh) else $error("enhanced depth not 128");
	property p_leg;
		legacy_extras_en != extended_en;
	endproperty
	a_leg: assert property (p_leg) else $error("legacy and enhanced overlap");
	property p_arb;
		arb_trigger_en |-> fifo_ctl_eff[7:4] == 4'h0 && extended_en;
	endproperty
	a_arb: assert property (p_arb) else $error("upper control bits kept");
	property p_ovs;
		sample_count >= 5'h04 && sample_count <= 5'h10;
	endproperty
	a_ovs: assert property (p_ovs) else $error("sample count out of range");
endmodule

// ==== verification/umcc_far_end.sv ====
`timescale 1ns/1ps
// Far side: external bit clocks and datapath fill levels
module umcc_far_end (
	input wire logic mclk,
	input wire logic run,
	output logic ring_ind_in,
	output logic data_set_ready_in,
	output logic [7:0] rx_fill_level,
	output logic [7:0] tx_fill_level
);
	logic [1:0] div_q = 2'h0;
	// Fixed levels stand in for the datapath counters
	assign rx_fill_level = 8'h2a;
	assign tx_fill_level = 8'h15;
	// Clocks stand still between transfers, mclk/4 otherwise
	always_ff @(posedge mclk) begin
		div_q <= run ? div_q + 2'h1 : 2'h0;
	end
	assign ring_ind_in = div_q[1];
	assign data_set_ready_in = div_q[1];
endmodule

// ==== verification/umcc_config_bench.sv ====
`timescale 1ns/1ps
module umcc_config_bench;
	import umcc_pkg::*;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic depth_select_pin = 1'b0;
	logic run = 1'b0;
	logic [7:0] reg_rdata, rxf, txf, ctl_eff;
	logic [7:0] rtv, flv, fhv;
	logic ri, dsr, leg, ext, arb, st, txt, rxt, tco, tcoe;
	umcc_depth_t depth;
	umcc_mode_e mode;
	logic [4:0] scnt;
	int fails = 0;
	int tests_run = 0;
	umcc_config i_umcc_config (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .depth_select_pin(depth_select_pin), .rx_fill_level(rxf),
		.tx_fill_level(txf), .ring_ind_in(ri), .data_set_ready_in(dsr), .fifo_depth(depth),
		.uart_mode(mode), .legacy_extras_en(leg), .extended_en(ext), .arb_trigger_en(arb),
		.fifo_ctl_eff(ctl_eff), .rx_trigger_level(rtv), .flow_low_threshold(flv),
		.flow_high_threshold(fhv), .sample_count(scnt), .sample_tick(st), .tx_bit_tick(txt),
		.rx_bit_tick(rxt), .tx_clk_out(tco), .tx_clk_out_en(tcoe));
	umcc_far_end i_umcc_far_end (.mclk(mclk), .run(run), .ring_ind_in(ri),
		.data_set_ready_in(dsr), .rx_fill_level(rxf), .tx_fill_level(txf));
	initial begin
		forever #2.5 mclk = ~mclk;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Bus cycles start on a rising edge and leave one idle cycle
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge mclk);
		reg_write <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge mclk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge mclk);
		reg_read <= 1'b0;
		@(negedge mclk);
		chk(reg_rdata, exp);
	endtask
	task automatic hold(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic t_reset;
		chk(depth, 8'h01);
		chk({2'h0, mode}, {2'h0, UMCC_MODE_450});
		chk({3'h0, scnt}, 8'h10);
		wr(4'h6, 8'h03);
		rd(4'h7, 8'h00);
		wr(4'h6, 8'h01);
		rd(4'h7, 8'h20);
		wr(4'hf, 8'h5a);
		rd(4'hf, 8'h00);
		rd(4'h8, 8'h2a);
		rd(4'h9, 8'h15);
	endtask
	task automatic mode_case(input logic [7:0] f, input logic [7:0] e, input logic p,
		input logic [7:0] dep, input logic [5:0] m);
		@(posedge mclk);
		depth_select_pin <= p;
		wr(4'h4, e);
		wr(4'h2, f);
		hold(3);
		chk(depth, dep);
		chk({2'h0, mode}, {2'h0, m});
		chk({6'h0, leg, ext}, {6'h0, ~e[4], e[4]});
	endtask
	task automatic t_modes;
		mode_case(8'h00, 8'h10, 1'b1, 8'h01, UMCC_MODE_450);
		mode_case(8'h01, 8'h00, 1'b0, 8'h10, UMCC_MODE_550);
		mode_case(8'h01, 8'h00, 1'b1, 8'h80, UMCC_MODE_X550);
		mode_case(8'h01, 8'h10, 1'b0, 8'h80, UMCC_MODE_650);
		mode_case(8'h21, 8'h00, 1'b0, 8'h10, UMCC_MODE_550);
		wr(4'h3, 8'h80);
		mode_case(8'h21, 8'h00, 1'b0, 8'h80, UMCC_MODE_750);
		wr(4'h3, 8'h03);
		wr(4'h3, 8'hbf);
		rd(4'h3, 8'h83);
		wr(4'h3, 8'h00);
	endtask
	task automatic t_arb;
		wr(4'h4, 8'h10);
		wr(4'h5, 8'h20);
		wr(4'h2, 8'hc1);
		hold(2);
		chk(ctl_eff, 8'h01);
		chk({7'h0, arb}, 8'h01);
		chk({2'h0, mode}, {2'h0, UMCC_MODE_950});
		wr(4'h5, 8'h00);
		wr(4'h4, 8'h00);
		// Level registers drive the threshold outputs
		wr(4'h6, 8'h04);
		wr(4'h7, 8'h11);
		wr(4'h6, 8'h05);
		wr(4'h7, 8'h22);
		wr(4'h6, 8'h06);
		wr(4'h7, 8'h33);
		hold(2);
		chk(rtv, 8'h11);
		chk(flv, 8'h22);
		chk(fhv, 8'h33);
		rd(4'h7, 8'h33);
	endtask
	// Cycles spanned by n ticks after the next tick
	task automatic span(input int b, input int n, input logic [7:0] exp);
		int k;
		int c;
		k = 0;
		c = 0;
		while ((b ? txt : st) !== 1'b1 && c < 500) begin
			@(negedge mclk);
			c++;
		end
		c = 0;
		while (k < n && c < 250) begin
			@(negedge mclk);
			c++;
			if ((b ? txt : st) === 1'b1) k++;
		end
		chk(c[7:0], exp);
	endtask
	task automatic t_rate;
		span(0, 8, 8'h20);
		span(1, 2, 8'h80);
		wr(4'h6, 8'h03);
		wr(4'h7, 8'h04);
		wr(4'h6, 8'h01);
		wr(4'h7, 8'h0c);
		span(0, 8, 8'h0c);
		span(1, 8, 8'h30);
		wr(4'ha, 8'h03);
		span(1, 4, 8'h48);
		wr(4'ha, 8'h01);
	endtask
	task automatic t_ovs;
		for (int v = 0; v < 16; v++) begin
			wr(4'h6, 8'h03);
			wr(4'h7, 8'(v));
			hold(2);
			chk({3'h0, scnt}, v < 4 ? 8'h10 : 8'(v));
		end
	endtask
	task automatic t_ext;
		int n;
		int m;
		logic t0;
		n = 0;
		m = 0;
		wr(4'h6, 8'h02);
		wr(4'h7, 8'h07);
		@(posedge mclk);
		run <= 1'b1;
		hold(2);
		chk({7'h0, tcoe}, 8'h01);
		t0 = tco;
		repeat (64) begin
			@(negedge mclk);
			if (txt === 1'b1 && rxt === 1'b1) n++;
			if (txt === 1'b1) m++;
		end
		chk({7'h0, n > 0}, 8'h01);
		// Transmit clock output toggles once per transmit bit
		chk({7'h0, tco}, {7'h0, t0 ^ m[0]});
		@(posedge mclk);
		run <= 1'b0;
		wr(4'h7, 8'h00);
	endtask
	initial begin
		repeat (6) @(posedge mclk);
		reset <= 1'b0;
		hold(1);
		t_reset;
		t_modes;
		t_arb;
		t_rate;
		t_ovs;
		t_ext;
		final_report;
	end
	// Watchdog well beyond the expected run of under a thousand cycles
	initial begin
		#250000;
		fails++;
		final_report;
	end
endmodule
bind umcc_config umcc_config_chk i_umcc_config_chk (.mclk(mclk), .reset(reset),
	.depth_select_pin(depth_select_pin), .fifo_depth(fifo_depth), .uart_mode(uart_mode),
	.legacy_extras_en(legacy_extras_en), .extended_en(extended_en),
	.arb_trigger_en(arb_trigger_en), .fifo_ctl_eff(fifo_ctl_eff), .sample_count(sample_count));
